// ===== common/pcm_defs.vh
// Constants for the PLL clock mode controller
`ifndef PCM_DEFS_VH
`define PCM_DEFS_VH

// Register byte offsets
`define PCM_REG_CTRL        12'h000
`define PCM_REG_STATUS      12'h004
`define PCM_REG_PATH        12'h008

// Control register fields
`define PCM_CTRL_PWR        0
`define PCM_CTRL_MASTER     1
`define PCM_CTRL_IN3        2
`define PCM_CTRL_MCKOE      3
`define PCM_CTRL_BCKRATE    4
`define PCM_CTRL_DIV_LO     5
`define PCM_CTRL_DIV_HI     6
`define PCM_CTRL_REF_LO     8
`define PCM_CTRL_REF_HI     11
`define PCM_CTRL_RATE_LO    12
`define PCM_CTRL_RATE_HI    15
`define PCM_CTRL_RESET      32'h0000_0000
`define PCM_CTRL_MASK       32'h0000_FF7F

// Path register fields
`define PCM_PATH_LINE       0
`define PCM_PATH_HP         1
`define PCM_PATH_RESET      32'h0000_0000
`define PCM_PATH_MASK       32'h0000_0003

// Reference select codes
`define PCM_REF_FRAME       4'h0
`define PCM_REF_BIT32       4'h2
`define PCM_REF_BIT64       4'h3
`define PCM_REF_M11M2896    4'h4
`define PCM_REF_M12M288     4'h5
`define PCM_REF_M12M        4'h6
`define PCM_REF_M24M        4'h7
`define PCM_REF_M19M2       4'h8
`define PCM_REF_M13M5       4'hC
`define PCM_REF_M27M        4'hD
`define PCM_REF_M13M        4'hE
`define PCM_REF_M26M        4'hF

// Lock class codes
`define PCM_LK_NONE         3'h0
`define PCM_LK_FRAME        3'h1
`define PCM_LK_BIT          3'h2
`define PCM_LK_MCLK         3'h3
`define PCM_LK_MCLK_SLOW    3'h4

// Maximum lock times in ms, clock rate in MHz
`define PCM_LOCK_FRAME_MS   160
`define PCM_LOCK_BIT_MS     4
`define PCM_LOCK_MCLK_MS    40
`define PCM_LOCK_SLOW_MS    60
`define PCM_CLK_MHZ         125
`define PCM_CLK_HZ          49'h0_0000_0773_5940

// Sampling rates in Hz
`define PCM_FS_7K35         16'h1CB6
`define PCM_FS_8K           16'h1F40
`define PCM_FS_11K025       16'h2B11
`define PCM_FS_12K          16'h2EE0
`define PCM_FS_14K7         16'h396C
`define PCM_FS_16K          16'h3E80
`define PCM_FS_22K05        16'h5622
`define PCM_FS_24K          16'h5DC0
`define PCM_FS_29K4         16'h72D8
`define PCM_FS_32K          16'h7D00
`define PCM_FS_44K1         16'hAC44
`define PCM_FS_48K          16'hBB80

// Divider chain taps on the 512fs tick counter
`define PCM_TAP_256FS       0
`define PCM_TAP_128FS       1
`define PCM_TAP_64FS        2
`define PCM_TAP_32FS        3
`define PCM_TAP_1FS         8
`define PCM_CHAIN_W         9

// NCO: accumulator width and fraction shift (512 * 2^24 = 2^33)
`define PCM_NCO_W           24
`define PCM_NCO_SHIFT       33

`endif

// ===== core/pcm_clock_ctrl.v
// PLL clock mode controller with APB register access
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "pcm_defs.vh"
module pcm_clock_ctrl #(
	parameter CW = 25,
	parameter [CW-1:0] LOCK_FRAME_CYC = `PCM_LOCK_FRAME_MS * 1000 * `PCM_CLK_MHZ,
	parameter [CW-1:0] LOCK_BIT_CYC   = `PCM_LOCK_BIT_MS * 1000 * `PCM_CLK_MHZ,
	parameter [CW-1:0] LOCK_MCLK_CYC  = `PCM_LOCK_MCLK_MS * 1000 * `PCM_CLK_MHZ,
	parameter [CW-1:0] LOCK_SLOW_CYC  = `PCM_LOCK_SLOW_MS * 1000 * `PCM_CLK_MHZ
) (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        bit_clock_in,
	output reg         bit_clock_out,
	output wire        bit_clock_oe,
	input  wire        frame_clock_in,
	output reg         frame_clock_out,
	output wire        frame_clock_oe,
	output reg         master_clock_output,
	output wire        pll_clock_active,
	output wire        sample_path_valid,
	output wire        dac_to_line_output,
	output wire        dac_to_headphone
);
	reg  [31:0]           ctrl;
	reg  [31:0]           path;
	reg                   pwr_q;
	reg  [3:0]            ref_q;
	reg  [3:0]            rate_q;
	reg                   locked;
	reg                   powerup_pending;
	reg  [CW-1:0]         lock_cnt;
	reg  [`PCM_CHAIN_W-1:0] chain;
	reg  [2:0]            lock_class;
	reg  [15:0]           fs_hz;
	reg                   rate_ok;
	reg  [CW-1:0]         lock_limit;
	reg                   next_mclk;
	reg                   next_bit;
	reg                   next_frame;
	wire                  pll_power_enable;
	wire                  master_select;
	wire                  input3_select;
	wire                  mclk_enable;
	wire                  bit_clock_rate_select;
	wire [1:0]            master_clock_divider;
	wire [3:0]            pll_reference_select;
	wire [3:0]            rate_select;
	wire                  rate_select_bit2;
	wire                  ref_ok;
	wire                  ref_is_mclk;
	wire                  pll_active;
	wire                  restart;
	wire                  lock_done;
	wire                  lock_rise;
	wire [`PCM_NCO_W-1:0] nco_inc;
	wire                  nco_tick;
	wire                  apb_access;
	wire                  apb_wr;
	wire                  hit_ctrl;
	wire                  hit_status;
	wire                  hit_path;
	wire                  hit_any;
	wire [31:0]           status;

	// Increment for a tick at 512fs from the core clock
	function [`PCM_NCO_W-1:0] nco_step;
		input [15:0] fs;
		reg   [48:0] wide;
		begin
			wide     = {fs, {`PCM_NCO_SHIFT{1'b0}}} / `PCM_CLK_HZ;
			nco_step = wide[`PCM_NCO_W-1:0];
		end
	endfunction

	assign pll_power_enable      = ctrl[`PCM_CTRL_PWR];
	assign master_select         = ctrl[`PCM_CTRL_MASTER];
	assign input3_select         = ctrl[`PCM_CTRL_IN3];
	assign mclk_enable           = ctrl[`PCM_CTRL_MCKOE];
	assign bit_clock_rate_select = ctrl[`PCM_CTRL_BCKRATE];
	assign master_clock_divider  = ctrl[`PCM_CTRL_DIV_HI:`PCM_CTRL_DIV_LO];
	assign pll_reference_select  = ctrl[`PCM_CTRL_REF_HI:`PCM_CTRL_REF_LO];
	assign rate_select           = ctrl[`PCM_CTRL_RATE_HI:`PCM_CTRL_RATE_LO];
	assign rate_select_bit2      = rate_select[2];

	// APB slave, zero wait states
	assign apb_access = psel & penable;
	assign apb_wr     = apb_access & pwrite;
	assign hit_ctrl   = (paddr == `PCM_REG_CTRL);
	assign hit_status = (paddr == `PCM_REG_STATUS);
	assign hit_path   = (paddr == `PCM_REG_PATH);
	assign hit_any    = hit_ctrl | hit_status | hit_path;
	assign pready     = 1'b1;
	// Unmapped offsets and writes to the status word answer with an error
	assign pslverr    = apb_access & (~hit_any | (pwrite & hit_status));

	always @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= `PCM_CTRL_RESET;
			path <= `PCM_PATH_RESET;
		end else if (apb_wr) begin
			if (hit_ctrl)
				ctrl <= pwdata & `PCM_CTRL_MASK;
			if (hit_path)
				path <= pwdata & `PCM_PATH_MASK;
		end
	end

	assign status = {27'h0, pll_active, ~rate_ok, ~ref_ok, powerup_pending, locked};

	always @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			if (hit_ctrl)
				prdata <= ctrl;
			else if (hit_status)
				prdata <= status;
			else if (hit_path)
				prdata <= path;
			else
				prdata <= 32'h0000_0000;
		end
	end

	assign dac_to_line_output = path[`PCM_PATH_LINE];
	assign dac_to_headphone   = path[`PCM_PATH_HP];

	// Reference decode and lock class
	always @* begin
		case (pll_reference_select)
		`PCM_REF_FRAME:    lock_class = `PCM_LK_FRAME;
		`PCM_REF_BIT32,
		`PCM_REF_BIT64:    lock_class = `PCM_LK_BIT;
		`PCM_REF_M11M2896,
		`PCM_REF_M12M288,
		`PCM_REF_M12M,
		`PCM_REF_M24M,
		`PCM_REF_M19M2,
		`PCM_REF_M13M5,
		`PCM_REF_M27M:     lock_class = `PCM_LK_MCLK;
		`PCM_REF_M13M,
		`PCM_REF_M26M:     lock_class = `PCM_LK_MCLK_SLOW;
		default:           lock_class = `PCM_LK_NONE;
		endcase
	end

	assign ref_ok      = (lock_class != `PCM_LK_NONE);
	assign ref_is_mclk = (lock_class == `PCM_LK_MCLK) || (lock_class == `PCM_LK_MCLK_SLOW);

	// Maximum lock time per class; the 13 and 26 MHz master clock references use the slower loop filter
	always @* begin
		case (lock_class)
		`PCM_LK_FRAME:     lock_limit = LOCK_FRAME_CYC;
		`PCM_LK_BIT:       lock_limit = LOCK_BIT_CYC;
		`PCM_LK_MCLK:      lock_limit = LOCK_MCLK_CYC;
		`PCM_LK_MCLK_SLOW: lock_limit = LOCK_SLOW_CYC;
		default:           lock_limit = {CW{1'b1}};
		endcase
	end

	// Sampling rate decode
	always @* begin
		rate_ok = 1'b1;
		fs_hz   = `PCM_FS_8K;
		if (ref_is_mclk) begin
			case (rate_select)
			4'h0:    fs_hz = `PCM_FS_8K;
			4'h1:    fs_hz = `PCM_FS_12K;
			4'h2:    fs_hz = `PCM_FS_16K;
			4'h3:    fs_hz = `PCM_FS_24K;
			4'h4:    fs_hz = `PCM_FS_7K35;
			4'h5:    fs_hz = `PCM_FS_11K025;
			4'h6:    fs_hz = `PCM_FS_14K7;
			4'h7:    fs_hz = `PCM_FS_22K05;
			4'hA:    fs_hz = `PCM_FS_32K;
			4'hB:    fs_hz = `PCM_FS_48K;
			4'hE:    fs_hz = `PCM_FS_29K4;
			4'hF:    fs_hz = `PCM_FS_44K1;
			default: rate_ok = 1'b0;
			endcase
		end else begin
			// Upper edge of each range; the real rate follows the host's clocks
			case ({rate_select[3], rate_select[1:0]})
			3'h0:    fs_hz = `PCM_FS_8K;
			3'h1:    fs_hz = `PCM_FS_12K;
			3'h2:    fs_hz = `PCM_FS_16K;
			3'h3:    fs_hz = `PCM_FS_24K;
			3'h6:    fs_hz = `PCM_FS_32K;
			3'h7:    fs_hz = `PCM_FS_48K;
			default: rate_ok = 1'b0;
			endcase
		end
	end

	// Only the rate bits that matter in this reference class restart the lock
	wire rate_changed;
	assign rate_changed = ref_is_mclk ? (rate_select != rate_q) :
		({rate_select[3], rate_select[1:0]} != {rate_q[3], rate_q[1:0]});

	assign pll_active = pll_power_enable & ~input3_select & ref_ok & rate_ok;
	assign restart    = (pll_power_enable & ~pwr_q) | rate_changed |
		(pll_reference_select != ref_q);
	assign lock_done  = (lock_cnt >= lock_limit - {{(CW-1){1'b0}}, 1'b1});
	assign lock_rise  = pll_active & ~restart & ~locked & lock_done;

	always @(posedge clk) begin
		if (!rst_b) begin
			pwr_q  <= 1'b0;
			ref_q  <= `PCM_REF_FRAME;
			rate_q <= 4'h0;
		end else begin
			pwr_q  <= pll_power_enable;
			ref_q  <= pll_reference_select;
			rate_q <= rate_select;
		end
	end

	// Lock timer and flag
	always @(posedge clk) begin
		if (!rst_b) begin
			lock_cnt <= {CW{1'b0}};
			locked   <= 1'b0;
		end else if (!pll_active || restart) begin
			lock_cnt <= {CW{1'b0}};
			locked   <= 1'b0;
		end else if (lock_rise) begin
			locked   <= 1'b1;
		end else if (!locked) begin
			lock_cnt <= lock_cnt + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// Power-up phase lasts from the enable's rising edge to the first lock
	always @(posedge clk) begin
		if (!rst_b)
			powerup_pending <= 1'b0;
		else if (pll_power_enable & ~pwr_q)
			powerup_pending <= 1'b1;
		else if (lock_rise || !pll_power_enable)
			powerup_pending <= 1'b0;
	end

	assign pll_clock_active  = pll_active & locked;
	assign sample_path_valid = locked;

	// Rate synthesis: NCO tick at 512fs feeds a binary divider chain
	assign nco_inc = nco_step(fs_hz);

	pcm_nco #(
		.W         (`PCM_NCO_W)
	) u_nco (
		.clk       (clk),
		.rst_b     (rst_b),
		.clear     (lock_rise),
		.increment (nco_inc),
		.tick      (nco_tick)
	);

	// Chain restarts at lock so the first frame after lock is a whole one
	always @(posedge clk) begin
		if (!rst_b || lock_rise)
			chain <= {`PCM_CHAIN_W{1'b0}};
		else if (nco_tick)
			chain <= chain + {{(`PCM_CHAIN_W-1){1'b0}}, 1'b1};
	end

	// The enable's first cycle is power-up too; the pending flag only follows it
	wire pwr_rise;
	assign pwr_rise = pll_power_enable & ~pwr_q;

	// Clock pin selection
	always @* begin
		next_mclk  = 1'b0;
		next_bit   = 1'b0;
		next_frame = 1'b0;
		if (mclk_enable && pll_active) begin
			// While unlocked the same taps run but carry no valid rate
			case (master_clock_divider)
			2'h0:    next_mclk = chain[`PCM_TAP_256FS];
			2'h1:    next_mclk = chain[`PCM_TAP_128FS];
			2'h2:    next_mclk = chain[`PCM_TAP_64FS];
			2'h3:    next_mclk = chain[`PCM_TAP_32FS];
			default: next_mclk = 1'b0;
			endcase
		end
		if (master_select && pll_active && !powerup_pending && !pwr_rise) begin
			next_frame = chain[`PCM_TAP_1FS];
			next_bit   = bit_clock_rate_select ? chain[`PCM_TAP_64FS] :
				chain[`PCM_TAP_32FS];
		end
	end

	// Pins go low with the enable off and with the PLL off; bit and frame pins also go low during power-up
	always @(posedge clk) begin
		if (!rst_b) begin
			master_clock_output <= 1'b0;
			bit_clock_out       <= 1'b0;
			frame_clock_out     <= 1'b0;
		end else begin
			master_clock_output <= next_mclk;
			bit_clock_out       <= next_bit;
			frame_clock_out     <= next_frame;
		end
	end

	// Bit and frame pins are inputs in slave role
	assign bit_clock_oe   = master_select;
	assign frame_clock_oe = master_select;

	// Slave-side clock inputs are references for the analog loop only
	wire unused_inputs;
	assign unused_inputs = bit_clock_in ^ frame_clock_in ^ rate_select_bit2;

endmodule

// ===== core/pcm_nco.v
// Phase accumulator producing a tick at a programmable rate
`timescale 1ns/1ns
module pcm_nco #(
	parameter W = 24
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         clear,
	input  wire [W-1:0] increment,
	output reg          tick
);
	reg  [W-1:0] phase;
	wire [W:0]   next_sum;

	assign next_sum = {1'b0, phase} + {1'b0, increment};

	// Carry out of the accumulator is the tick; jitter is one clk period
	always @(posedge clk) begin
		if (!rst_b || clear) begin
			phase <= {W{1'b0}};
			tick  <= 1'b0;
		end else begin
			phase <= next_sum[W-1:0];
			tick  <= next_sum[W];
		end
	end
endmodule

// ===== verif/pcm_clock_ctrl_props.sv
// Port-level assertions for the clock mode controller
`timescale 1ns/1ns
module pcm_clock_ctrl_props (
	input wire        clk,
	input wire        rst_b,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire        bit_clock_out,
	input wire        bit_clock_oe,
	input wire        frame_clock_out,
	input wire        frame_clock_oe,
	input wire        pll_clock_active,
	input wire        sample_path_valid,
	input wire        dac_to_line_output,
	input wire        dac_to_headphone
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic acc;
	logic cw;
	assign acc = psel && penable;
	assign cw = acc && pwrite && paddr == 12'h000;
	sequence s_path_wr;
		acc && pwrite && paddr == 12'h008;
	endsequence
	ready_high_a: assert property (acc |-> pready)
		else $error("pready low in access");
	err_place_a: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	err_map_a: assert property (acc && (paddr > 12'h008 || (pwrite && paddr == 12'h004)) |-> pslverr)
		else $error("bad access not refused");
	oe_pair_a: assert property (bit_clock_oe == frame_clock_oe)
		else $error("pin enables differ");
	slave_quiet_a: assert property (!bit_clock_oe && $past(!bit_clock_oe)
		|-> !bit_clock_out && !frame_clock_out)
		else $error("clock pins toggle in slave role");
	active_lock_a: assert property (pll_clock_active |-> sample_path_valid)
		else $error("active without lock");
	path_wr_a: assert property (s_path_wr |=> dac_to_line_output == $past(pwdata[0])
		&& dac_to_headphone == $past(pwdata[1]))
		else $error("path bits not updated");
	// A control write may legally drop lock up to three cycles later
	hold_lock_a: assert property (pll_clock_active && !cw && !$past(cw) && !$past(cw, 2)
		|=> pll_clock_active)
		else $error("lock lost without cause");
	sequence s_pwr_off;
		cw && !pwdata[0];
	endsequence
	pwr_off_a: assert property (s_pwr_off |-> ##2 !bit_clock_out && !frame_clock_out
		&& !pll_clock_active)
		else $error("clocks run after power off");
endmodule
bind pcm_clock_ctrl pcm_clock_ctrl_props u_props (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
	.frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
	.pll_clock_active(pll_clock_active), .sample_path_valid(sample_path_valid),
	.dac_to_line_output(dac_to_line_output), .dac_to_headphone(dac_to_headphone));

// ===== verif/pcm_host_model.sv
// Host audio processor model: slave clocks out, generated clocks measured
`timescale 1ns/1ns
module pcm_host_model (
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic        bit_clock_out,
	input  wire logic        frame_clock_out,
	input  wire logic        master_clock_output,
	output logic             bit_clock_in,
	output logic             frame_clock_in,
	output logic [15:0]      frame_len,
	output logic [9:0]       bits_seen,
	output logic [9:0]       mck_seen,
	output logic [7:0]       frames
);
	logic [15:0] cyc;
	logic [9:0]  bcnt;
	logic [9:0]  mcnt;
	logic [11:0] div;
	logic        bq;
	logic        fq;
	logic        mq;
	initial begin
		{bit_clock_in, frame_clock_in, frame_len, bits_seen, mck_seen, frames} = '0;
		{cyc, bcnt, mcnt, div, bq, fq, mq} = '0;
	end
	always @(posedge clk) begin
		// Slave clocks stand still low between runs, 64 bit periods a frame
		div <= run ? div + 12'h001 : 12'h000;
		bit_clock_in <= run & div[4];
		frame_clock_in <= run & div[10];
		bq <= bit_clock_out;
		fq <= frame_clock_out;
		mq <= master_clock_output;
		cyc <= cyc + 16'h0001;
		bcnt <= bcnt + {9'h000, bit_clock_out & ~bq};
		mcnt <= mcnt + {9'h000, master_clock_output & ~mq};
		// Edges that land on the frame edge belong to the new frame
		if (frame_clock_out & ~fq) begin
			frame_len <= cyc;
			bits_seen <= bcnt;
			mck_seen <= mcnt;
			frames <= frames + 8'h01;
			cyc <= 16'h0001;
			bcnt <= {9'h000, bit_clock_out & ~bq};
			mcnt <= {9'h000, master_clock_output & ~mq};
		end
	end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the clock mode controller
`timescale 1ns/1ns
module tb;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er, run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        bci, bco, bcoe, fci, fco, fcoe, mck, act, spv, dl, dh;
	logic [15:0] flen;
	logic [9:0]  bseen, mseen;
	logic [7:0]  frames;
	int          fails, tests_run;
	// Short lock counts keep the run small; distinct so a mixed-up mode shows
	pcm_clock_ctrl #(.LOCK_FRAME_CYC(25'h28), .LOCK_BIT_CYC(25'h14), .LOCK_MCLK_CYC(25'h1E),
		.LOCK_SLOW_CYC(25'h23)) DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bit_clock_in(bci), .bit_clock_out(bco), .bit_clock_oe(bcoe),
		.frame_clock_in(fci), .frame_clock_out(fco), .frame_clock_oe(fcoe),
		.master_clock_output(mck), .pll_clock_active(act), .sample_path_valid(spv),
		.dac_to_line_output(dl), .dac_to_headphone(dh));
	pcm_host_model u_host (.clk(clk), .run(run), .bit_clock_out(bco), .frame_clock_out(fco),
		.master_clock_output(mck), .bit_clock_in(bci), .frame_clock_in(fci),
		.frame_len(flen), .bits_seen(bseen), .mck_seen(mseen), .frames(frames));
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task hang;
		fails++;
		conclude();
	endtask
	task chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [31:0] cw(input logic ms, input logic oe, input logic bck,
		input logic [1:0] dv, input logic [3:0] rf, input logic [3:0] rt, input logic in3);
		return {16'h0000, rt, rf, 1'b0, dv, bck, oe, in3, ms, 1'b1};
	endfunction
	// Power down first so every attempt starts from a fresh power-up
	task lock(input logic [31:0] c, input int lim);
		int n;
		apb(1'b1, 12'h000, c & 32'hFFFF_FFFE);
		apb(1'b1, 12'h000, c);
		n = 0;
		while (act !== 1'b1 && n < 120) begin
			@(posedge clk);
			n++;
			if (c[1] && (bco | fco) !== 1'b0)
				chk(1'b0, "clock pin before lock");
		end
		if (lim == 0)
			chk(n == 120 && spv === 1'b0, "locked on bad setting");
		else if (n == 120)
			hang();
		else
			chk(n >= lim - 1 && n <= lim + 3, "lock time");
	endtask
	task t_reset;
		chk(bcoe === 1'b0 && fcoe === 1'b0 && mck === 1'b0 && spv === 1'b0, "reset pins");
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd === 32'h0000_0000 && er === 1'b0, "control reset");
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk(rd === 32'h0000_0000, "path reset");
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk(rd === 32'h0000_0000 && er === 1'b1, "unmapped read");
		apb(1'b1, 12'h004, 32'hFFFF_FFFF);
		chk(er === 1'b1, "status write");
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd === 32'h0000_FF7F, "control mask");
		apb(1'b1, 12'h000, 32'h0000_0000);
	endtask
	task t_lock;
		int lt [16] = '{40, 0, 20, 20, 30, 30, 30, 30, 30, 0, 0, 0, 30, 30, 35, 35};
		for (int r = 0; r < 16; r++)
			lock(cw(1'b1, 1'b1, 1'b0, 2'h0, r[3:0], 4'hB, 1'b0), lt[r]);
	endtask
	task t_rate;
		logic [15:0] okm;
		logic [7:0]  okf;
		okm = 16'hCCFF;
		okf = 8'hCF;
		for (int r = 0; r < 16; r++) begin
			lock(cw(1'b0, 1'b0, 1'b0, 2'h0, 4'h5, r[3:0], 1'b0), okm[r] ? 30 : 0);
			lock(cw(1'b0, 1'b0, 1'b0, 2'h0, 4'h3, r[3:0], 1'b0),
				okf[{r[3], r[1:0]}] ? 20 : 0);
		end
	endtask
	task t_misc;
		lock(cw(1'b1, 1'b1, 1'b0, 2'h0, 4'h5, 4'hB, 1'b1), 0);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(rd === 32'h0000_0002 && er === 1'b0, "status with input 3 set");
		lock(cw(1'b0, 1'b0, 1'b0, 2'h0, 4'h0, 4'h3, 1'b0), 40);
		apb(1'b1, 12'h000, cw(1'b0, 1'b0, 1'b0, 2'h0, 4'h0, 4'h7, 1'b0));
		repeat (50) @(posedge clk);
		chk(spv === 1'b1 && act === 1'b1, "rate bit 2 restarted lock");
		apb(1'b1, 12'h000, cw(1'b0, 1'b0, 1'b0, 2'h0, 4'h0, 4'h2, 1'b0));
		repeat (4) @(posedge clk);
		chk(spv === 1'b0, "rate change kept lock");
	endtask
	task t_clocks;
		logic [7:0] f;
		int n;
		for (int i = 0; i < 4; i++) begin
			if (i == 0)
				lock(cw(1'b1, 1'b1, 1'b0, 2'h0, 4'h5, 4'hB, 1'b0), 30);
			else
				apb(1'b1, 12'h000, cw(1'b1, 1'b1, i[0], i[1:0], 4'h5, 4'hB, 1'b0));
			f = frames + 8'h03;
			n = 0;
			while (frames !== f && n < 12000) begin
				@(posedge clk);
				n++;
			end
			if (n == 12000)
				hang();
			chk(flen >= 16'h0A2B && flen <= 16'h0A2E, "frame period");
			chk(bseen === (i[0] ? 10'h040 : 10'h020), "bit clocks a frame");
			chk(mseen === (10'h100 >> i), "master clocks a frame");
			chk(bcoe === 1'b1 && fcoe === 1'b1, "master pin enables");
		end
	endtask
	task t_off;
		int n;
		apb(1'b1, 12'h000, cw(1'b1, 1'b1, 1'b0, 2'h0, 4'h5, 4'hB, 1'b0) & 32'hFFFF_FFFE);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (3000) begin
			@(posedge clk);
			if ((bco | fco | mck) !== 1'b0)
				n++;
		end
		chk(n == 0 && spv === 1'b0, "clocks after power off");
	endtask
	task t_slave;
		int n;
		run <= 1'b1;
		apb(1'b1, 12'h008, 32'h0000_0003);
		@(posedge clk);
		chk(dl === 1'b1 && dh === 1'b1, "path bits set");
		lock(cw(1'b0, 1'b0, 1'b0, 2'h3, 4'h5, 4'hB, 1'b0), 30);
		apb(1'b1, 12'h008, 32'h0000_0000);
		@(posedge clk);
		chk(dl === 1'b0 && dh === 1'b0, "mute");
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (mck !== 1'b0)
				n++;
		end
		chk(n == 0 && spv === 1'b1, "master clock with enable low");
		apb(1'b1, 12'h000, cw(1'b0, 1'b1, 1'b0, 2'h3, 4'h5, 4'hB, 1'b0));
		n = 0;
		repeat (200) begin
			@(posedge clk);
			if (mck === 1'b1)
				n++;
		end
		chk(n > 60 && n < 140, "master clock with enable high");
		run <= 1'b0;
	endtask
	// Reset in mid-run must drop back to slave role with all pins quiet
	task t_rerst;
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk(bcoe === 1'b0 && mck === 1'b0 && spv === 1'b0 && act === 1'b0, "pins in reset");
		rst_b <= 1'b1;
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(rd === 32'h0000_0000 && er === 1'b0, "control after reset");
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_b, psel, penable, pwrite, run} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_lock();
		t_rate();
		t_misc();
		t_clocks();
		t_off();
		t_slave();
		t_rerst();
		conclude();
	end
endmodule
